/* File: tcp_defs.vh */
// Register offsets, field positions and reset values of the two-channel PWM timer
`ifndef TCP_DEFS_VH
`define TCP_DEFS_VH

// Register offsets on the die link register port
`define TCP_OFF_PRESCALE 8'h61
`define TCP_OFF_SCALE_A 8'h62
`define TCP_OFF_SCALE_B 8'h63
`define TCP_OFF_COUNTER0 8'h64
`define TCP_OFF_COUNTER1 8'h65
`define TCP_OFF_PERIOD0 8'h66
`define TCP_OFF_PERIOD1 8'h67
`define TCP_OFF_DUTY0 8'h68
`define TCP_OFF_DUTY1 8'h69

// Prescale select register field positions
`define TCP_PRE_A_LSB 0
`define TCP_PRE_A_MSB 2
`define TCP_PRE_B_LSB 4
`define TCP_PRE_B_MSB 6

// Reset values
`define TCP_RST_BYTE 8'h00
`define TCP_RST_SEL 3'h0

// Scaled clock down counter reload point
`define TCP_SCALE_END 8'h01

`endif

/* File: tcp_pwm_channel.v */
// One PWM channel: counter, double-buffered period and duty, output flip-flop
`timescale 1ns/1ns
module tcp_pwm_channel #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // Channel clock tick and controls
    input wire tick_in,
    input wire enable_in,
    input wire polarity_in,
    input wire center_in,
    // Register writes
    input wire period_wr_in,
    input wire duty_wr_in,
    input wire counter_wr_in,
    input wire [WIDTH-1:0] wdata_in,
    // State for read-back and output
    output wire [WIDTH-1:0] counter_out,
    output wire [WIDTH-1:0] period_buf_out,
    output wire [WIDTH-1:0] duty_buf_out,
    output reg pwm_out
);

    reg [WIDTH-1:0] cnt_q, cnt_d;
    reg [WIDTH-1:0] per_buf_q, per_buf_d;
    reg [WIDTH-1:0] dty_buf_q, dty_buf_d;
    reg [WIDTH-1:0] per_act_q, per_act_d;
    reg [WIDTH-1:0] dty_act_q, dty_act_d;
    reg down_q, down_d;
    reg flip_q, flip_d;
    reg en_sync_q, en_sync_d;
    reg [WIDTH:0] cnt_inc;
    reg [WIDTH-1:0] cnt_n;
    reg period_end;

    assign counter_out = cnt_q;
    assign period_buf_out = per_buf_q;
    assign duty_buf_out = dty_buf_q;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always @* begin
        per_buf_d = period_wr_in ? wdata_in : per_buf_q;
        dty_buf_d = duty_wr_in ? wdata_in : dty_buf_q;
        per_act_d = per_act_q;
        dty_act_d = dty_act_q;
        cnt_d = cnt_q;
        down_d = down_q;
        flip_d = flip_q;
        cnt_inc = {1'b0, cnt_q} + {{WIDTH{1'b0}}, 1'b1};
        cnt_n = cnt_q;
        period_end = 1'b0;
        // Enable only takes hold at a channel clock edge
        en_sync_d = tick_in ? enable_in : en_sync_q; // [R17] [R18]
        if (counter_wr_in) begin
            // Counter write restarts the period with fresh settings
            cnt_d = {WIDTH{1'b0}}; // [R20]
            down_d = 1'b0;
            flip_d = 1'b0; // [R20]
            per_act_d = per_buf_d; // [R1] [R4] [R22]
            dty_act_d = dty_buf_d;
        end else if (!enable_in) begin
            // Disabled: latches follow the buffers, counter holds
            per_act_d = per_buf_d; // [R1] [R2] [R4] [R5]
            dty_act_d = dty_buf_d;
        end else if (tick_in && en_sync_q) begin // [R18]
            if (!center_in) begin
                // Left aligned: 0 .. period-1
                if (cnt_inc >= {1'b0, per_act_q}) begin // [R16] [R21] [R8]
                    period_end = 1'b1;
                    cnt_n = {WIDTH{1'b0}};
                end else begin
                    cnt_n = cnt_inc[WIDTH-1:0];
                end
            end else if (!down_q) begin
                // Center aligned: up to period, then down to 0
                cnt_n = cnt_inc[WIDTH-1:0]; // [R21] [R8]
                if (cnt_inc >= {1'b0, per_act_q}) begin
                    down_d = 1'b1;
                end
            end else begin
                cnt_n = cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
                if (cnt_q <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                    period_end = 1'b1;
                    cnt_n = {WIDTH{1'b0}};
                    down_d = 1'b0;
                end
            end
            cnt_d = cnt_n;
            if (period_end) begin
                // Period and duty switch together at the period boundary
                per_act_d = per_buf_d; // [R1] [R4] [R22]
                dty_act_d = dty_buf_d; // [R22]
                flip_d = 1'b0;
            end else if (cnt_n == dty_act_q) begin
                flip_d = ~flip_q; // [R6]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_q <= {WIDTH{1'b0}};
            per_buf_q <= {WIDTH{1'b0}};
            dty_buf_q <= {WIDTH{1'b0}};
            per_act_q <= {WIDTH{1'b0}};
            dty_act_q <= {WIDTH{1'b0}};
            down_q <= 1'b0;
            flip_q <= 1'b0;
            en_sync_q <= 1'b0;
            pwm_out <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            per_buf_q <= per_buf_d;
            dty_buf_q <= dty_buf_d;
            per_act_q <= per_act_d;
            dty_act_q <= dty_act_d;
            down_q <= down_d;
            flip_q <= flip_d;
            en_sync_q <= en_sync_d;
            // Polarity picks Q or inverted Q; output path gated by enable
            pwm_out <= enable_in & (flip_d ^ polarity_in); // [R7] [R17]
        end
    end

endmodule // tcp_pwm_channel

/* File: tcp_pwm_timer.v */
// Two-channel 8-bit PWM timer: clock tree, register port and two channels
`timescale 1ns/1ns
`include "tcp_defs.vh"

// Contract
// R1 - Period double buffered while channel enabled
// R2 - Disabled period write updates latch and buffer
// R3 - Period and duty reads return buffer
// R4 - Duty double buffered like period
// R5 - Disabled duty write updates latch too
// R6 - Duty match toggles output flip-flop
// R7 - Polarity sets start level of period
// R8 - Period is clock times period, centre doubled
// R9 - Four clocks: A, B, scaled A, B
// R10 - Prescalers divide by one to 128
// R11 - Prescaler stops when both channels disabled
// R12 - Scaled clock: 8-bit down counter, halved
// R13 - Scale zero means 256, divide 512
// R14 - Scale write reloads down counter at once
// R15 - Channel picks prescaled or scaled clock
// R16 - 8-bit counter, period, duty per channel
// R17 - Waveform starts at next channel clock
// R18 - Enable synchronised; disabled counter holds
// R19 - Software avoids clock changes while running
// R20 - Counter write clears, reloads, resets output
// R21 - Left counts to period-1, centre up/down
// R22 - Period and duty switch in same cycle
module tcp_pwm_timer (
    // Clock and reset
    input wire REF_CLK_IN,
    input wire RST_N_IN,
    // Die link register port
    input wire [7:0] REG_ADDR_IN,
    input wire REG_WR_IN,
    input wire REG_RD_IN,
    input wire [7:0] REG_WDATA_IN,
    output reg [7:0] REG_RDATA_OUT,
    // Control bits held in the control register
    input wire [1:0] CHANNEL_ENABLE_BIT_IN,
    input wire [1:0] START_POLARITY_IN,
    input wire [1:0] CENTER_ALIGN_SELECT_IN,
    input wire [1:0] CHANNEL_CLOCK_CHOICE_IN,
    // PWM outputs
    output wire [1:0] PWM_OUT
);

    // Clock tree registers
    reg [2:0] prescale_a_select_q;
    reg [2:0] prescale_b_select_q;
    reg [7:0] scale_a_value_q;
    reg [7:0] scale_b_value_q;
    reg [6:0] pre_cnt_q;
    reg [7:0] scl_a_cnt_q;
    reg [7:0] scl_b_cnt_q;
    reg half_a_q;
    reg half_b_q;

    // Clock tree ticks
    wire pre_run;
    wire tick_a;
    wire tick_b;
    wire pulse_a;
    wire pulse_b;
    wire tick_sa;
    wire tick_sb;
    wire [1:0] ch_tick;

    // Register write strobes
    wire wr_pre;
    wire wr_sa;
    wire wr_sb;
    wire wr_per0;
    wire wr_per1;
    wire wr_dty0;
    wire wr_dty1;
    wire wr_cnt0;
    wire wr_cnt1;

    // Channel state for read-back
    wire [7:0] cnt0, cnt1, per0, per1, dty0, dty1;
    reg [7:0] rdata_d;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Prescaled tick: all low select bits of the prescale counter are ones
    function pre_tick;
        input [6:0] cnt;
        input [2:0] sel;
        reg [6:0] mask;
        begin
            mask = ~(7'h7f << sel);
            pre_tick = ((cnt & mask) == mask);
        end
    endfunction

    // Write strobe for one offset
    function wr_hit;
        input [7:0] addr;
        input [7:0] off;
        input wr;
        begin
            wr_hit = wr && (addr == off);
        end
    endfunction

    // Scale down counter next value: a write reloads at once, the end pulse reloads, a tick counts down
    function [7:0] scl_next;
        input [7:0] cnt;
        input [7:0] scale;
        input [7:0] wdata;
        input wr;
        input tick;
        begin
            if (wr) begin
                scl_next = wdata; // [R14]
            end else if (tick && (cnt == `TCP_SCALE_END)) begin
                scl_next = scale; // [R12]
            end else if (tick) begin
                scl_next = cnt - 8'h01; // [R13]
            end else begin
                scl_next = cnt;
            end
        end
    endfunction

    // Channel clock: prescaled tick, or scaled tick when the choice bit is set
    function ch_clock;
        input choice;
        input pre;
        input scl;
        begin
            ch_clock = choice ? scl : pre;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register writes

    assign wr_pre = wr_hit(REG_ADDR_IN, `TCP_OFF_PRESCALE, REG_WR_IN);
    assign wr_sa = wr_hit(REG_ADDR_IN, `TCP_OFF_SCALE_A, REG_WR_IN);
    assign wr_sb = wr_hit(REG_ADDR_IN, `TCP_OFF_SCALE_B, REG_WR_IN);
    assign wr_per0 = wr_hit(REG_ADDR_IN, `TCP_OFF_PERIOD0, REG_WR_IN);
    assign wr_per1 = wr_hit(REG_ADDR_IN, `TCP_OFF_PERIOD1, REG_WR_IN);
    assign wr_dty0 = wr_hit(REG_ADDR_IN, `TCP_OFF_DUTY0, REG_WR_IN);
    assign wr_dty1 = wr_hit(REG_ADDR_IN, `TCP_OFF_DUTY1, REG_WR_IN);
    assign wr_cnt0 = wr_hit(REG_ADDR_IN, `TCP_OFF_COUNTER0, REG_WR_IN); // [R20]
    assign wr_cnt1 = wr_hit(REG_ADDR_IN, `TCP_OFF_COUNTER1, REG_WR_IN); // [R20]

    // Prescale selects for clocks A and B
    always @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            prescale_a_select_q <= `TCP_RST_SEL;
            prescale_b_select_q <= `TCP_RST_SEL;
        end else if (wr_pre) begin
            prescale_a_select_q <= REG_WDATA_IN[`TCP_PRE_A_MSB:`TCP_PRE_A_LSB]; // [R10]
            prescale_b_select_q <= REG_WDATA_IN[`TCP_PRE_B_MSB:`TCP_PRE_B_LSB]; // [R10]
        end
    end

    // Scale values for the scaled clocks
    always @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            scale_a_value_q <= `TCP_RST_BYTE;
            scale_b_value_q <= `TCP_RST_BYTE;
        end else begin
            if (wr_sa) begin
                scale_a_value_q <= REG_WDATA_IN;
            end
            if (wr_sb) begin
                scale_b_value_q <= REG_WDATA_IN;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler: one counter serves clocks A and B

    assign pre_run = |CHANNEL_ENABLE_BIT_IN; // [R11]

    // Prescale counter held at zero while both channels are off
    always @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            pre_cnt_q <= 7'h00;
        end else if (!pre_run) begin
            pre_cnt_q <= 7'h00; // [R11]
        end else begin
            pre_cnt_q <= pre_cnt_q + 7'h01;
        end
    end

    assign tick_a = pre_run && pre_tick(pre_cnt_q, prescale_a_select_q); // [R9] [R10]
    assign tick_b = pre_run && pre_tick(pre_cnt_q, prescale_b_select_q); // [R9] [R10]

    ////////////////////////////////////////////////////////////////////////////
    // Scalers: down counter to one, reload, then divide by two

    // Zero loads as 0 and wraps, giving 256 counts
    assign pulse_a = tick_a && (scl_a_cnt_q == `TCP_SCALE_END); // [R12] [R13]
    assign pulse_b = tick_b && (scl_b_cnt_q == `TCP_SCALE_END); // [R12] [R13]

    // Scaled clock edge on every second reload pulse
    assign tick_sa = pulse_a && half_a_q; // [R12]
    assign tick_sb = pulse_b && half_b_q; // [R12]

    // Scaler A down counter and halving flop
    always @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            scl_a_cnt_q <= `TCP_RST_BYTE;
            half_a_q <= 1'b0;
        end else begin
            scl_a_cnt_q <= scl_next(scl_a_cnt_q, scale_a_value_q, REG_WDATA_IN, wr_sa, tick_a); // [R14]
            if (pulse_a) begin
                half_a_q <= ~half_a_q; // [R12]
            end
        end
    end

    // Scaler B down counter and halving flop
    always @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            scl_b_cnt_q <= `TCP_RST_BYTE;
            half_b_q <= 1'b0;
        end else begin
            scl_b_cnt_q <= scl_next(scl_b_cnt_q, scale_b_value_q, REG_WDATA_IN, wr_sb, tick_b); // [R14]
            if (pulse_b) begin
                half_b_q <= ~half_b_q; // [R12]
            end
        end
    end

    // Per-channel clock choice
    assign ch_tick[0] = ch_clock(CHANNEL_CLOCK_CHOICE_IN[0], tick_a, tick_sa); // [R15]
    assign ch_tick[1] = ch_clock(CHANNEL_CLOCK_CHOICE_IN[1], tick_b, tick_sb); // [R15]

    ////////////////////////////////////////////////////////////////////////////
    // Channels

    tcp_pwm_channel #(
        .WIDTH(8)
    ) u_ch0 (
        .clk_in(REF_CLK_IN),
        .rst_n_in(RST_N_IN),
        .tick_in(ch_tick[0]),
        .enable_in(CHANNEL_ENABLE_BIT_IN[0]),
        .polarity_in(START_POLARITY_IN[0]),
        .center_in(CENTER_ALIGN_SELECT_IN[0]),
        .period_wr_in(wr_per0),
        .duty_wr_in(wr_dty0),
        .counter_wr_in(wr_cnt0), // [R20]
        .wdata_in(REG_WDATA_IN),
        .counter_out(cnt0),
        .period_buf_out(per0),
        .duty_buf_out(dty0),
        .pwm_out(PWM_OUT[0])
    );

    tcp_pwm_channel #(
        .WIDTH(8)
    ) u_ch1 (
        .clk_in(REF_CLK_IN),
        .rst_n_in(RST_N_IN),
        .tick_in(ch_tick[1]),
        .enable_in(CHANNEL_ENABLE_BIT_IN[1]),
        .polarity_in(START_POLARITY_IN[1]),
        .center_in(CENTER_ALIGN_SELECT_IN[1]),
        .period_wr_in(wr_per1),
        .duty_wr_in(wr_dty1),
        .counter_wr_in(wr_cnt1), // [R20]
        .wdata_in(REG_WDATA_IN),
        .counter_out(cnt1),
        .period_buf_out(per1),
        .duty_buf_out(dty1),
        .pwm_out(PWM_OUT[1])
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read-back, registered; unmapped offsets read zero

    // Read data selection
    always @* begin
        case (REG_ADDR_IN)
            `TCP_OFF_PRESCALE: rdata_d = {1'b0, prescale_b_select_q, 1'b0, prescale_a_select_q};
            `TCP_OFF_SCALE_A: rdata_d = scale_a_value_q;
            `TCP_OFF_SCALE_B: rdata_d = scale_b_value_q;
            `TCP_OFF_COUNTER0: rdata_d = cnt0;
            `TCP_OFF_COUNTER1: rdata_d = cnt1;
            `TCP_OFF_PERIOD0: rdata_d = per0; // [R3]
            `TCP_OFF_PERIOD1: rdata_d = per1; // [R3]
            `TCP_OFF_DUTY0: rdata_d = dty0; // [R3]
            `TCP_OFF_DUTY1: rdata_d = dty1; // [R3]
            default: rdata_d = 8'h00;
        endcase
    end

    // Read data register, held until the next read
    always @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            REG_RDATA_OUT <= `TCP_RST_BYTE;
        end else if (REG_RD_IN) begin
            REG_RDATA_OUT <= rdata_d;
        end
    end

endmodule // tcp_pwm_timer

/* File: tcp_pwm_timer_monitor.sv */
// Checker for the register port and PWM outputs of the PWM timer
`timescale 1ns/1ns
module tcp_pwm_timer_monitor (
    // Clock and reset
    input wire REF_CLK_IN,
    input wire RST_N_IN,
    // Register port
    input wire [7:0] REG_ADDR_IN,
    input wire REG_WR_IN,
    input wire REG_RD_IN,
    input wire [7:0] REG_WDATA_IN,
    input wire [7:0] REG_RDATA_OUT,
    // Channel controls and outputs
    input wire [1:0] CHANNEL_ENABLE_BIT_IN,
    input wire [1:0] START_POLARITY_IN,
    input wire [1:0] CENTER_ALIGN_SELECT_IN,
    input wire [1:0] CHANNEL_CLOCK_CHOICE_IN,
    input wire [1:0] PWM_OUT
);
    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    ////////////////////////////////////////////////////////////////////////////////
    // Register port
    AST_RESET_VALUES: assert property ($rose(RST_N_IN) |-> PWM_OUT == 2'b00 && REG_RDATA_OUT == 8'h00)
        else $error("outputs not cleared by reset");
    AST_READ_HOLDS: assert property (!REG_RD_IN |=> $stable(REG_RDATA_OUT))
        else $error("read data moved without a read");
    AST_UNMAPPED_ZERO: assert property (REG_RD_IN && (REG_ADDR_IN < 8'h61 || REG_ADDR_IN > 8'h69) |=> REG_RDATA_OUT == 8'h00)
        else $error("unmapped read not zero");
    AST_PERIOD_READBACK: assert property (REG_WR_IN && REG_ADDR_IN == 8'h66 ##1 !REG_WR_IN ##1 REG_RD_IN && !REG_WR_IN && REG_ADDR_IN == 8'h66 |=> REG_RDATA_OUT == $past(REG_WDATA_IN, 3))
        else $error("period read differs from last write");
    AST_DUTY_READBACK: assert property (REG_WR_IN && (REG_ADDR_IN == 8'h68 || REG_ADDR_IN == 8'h69) ##1 !REG_WR_IN ##1 REG_RD_IN && !REG_WR_IN && REG_ADDR_IN == $past(REG_ADDR_IN, 2) |=> REG_RDATA_OUT == $past(REG_WDATA_IN, 3))
        else $error("duty read differs from last write");

    ////////////////////////////////////////////////////////////////////////////////
    // Channel outputs
    AST_CH0_OFF_LOW: assert property (!CHANNEL_ENABLE_BIT_IN[0] |=> !PWM_OUT[0])
        else $error("channel 0 output high while disabled");
    AST_CH1_OFF_LOW: assert property (!CHANNEL_ENABLE_BIT_IN[1] [*2] |-> !PWM_OUT[1])
        else $error("channel 1 output high while disabled");
    AST_COUNTER_WRITE_LEVEL: assert property (REG_WR_IN && REG_ADDR_IN == 8'h64 && CHANNEL_ENABLE_BIT_IN[0] |=> PWM_OUT[0] == $past(START_POLARITY_IN[0]))
        else $error("counter write did not restart at polarity level");
endmodule // tcp_pwm_timer_monitor

bind tcp_pwm_timer tcp_pwm_timer_monitor u_monitor (
    .REF_CLK_IN(REF_CLK_IN), .RST_N_IN(RST_N_IN), .REG_ADDR_IN(REG_ADDR_IN), .REG_WR_IN(REG_WR_IN),
    .REG_RD_IN(REG_RD_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
    .CHANNEL_ENABLE_BIT_IN(CHANNEL_ENABLE_BIT_IN), .START_POLARITY_IN(START_POLARITY_IN),
    .CENTER_ALIGN_SELECT_IN(CENTER_ALIGN_SELECT_IN), .CHANNEL_CLOCK_CHOICE_IN(CHANNEL_CLOCK_CHOICE_IN),
    .PWM_OUT(PWM_OUT)
);

/* File: test_tcp_pwm_timer.sv */
// Self-checking bench for the two-channel PWM timer
`timescale 1ns/1ns
module test_tcp_pwm_timer;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [1:0] en = 2'b00;
    logic [1:0] pol = 2'b00;
    logic [1:0] ctr = 2'b00;
    logic [1:0] cho = 2'b00;
    wire [7:0] rdata;
    wire [1:0] pwm;
    int n_mismatch = 0;
    int num_checks = 0;
    // Rows of offset, write data, expected read data
    logic [23:0] rows [0:8] = '{24'h61ff77, 24'h62a5a5, 24'h633c3c, 24'h668181, 24'h677e7e,
                                24'h684242, 24'h692424, 24'h649900, 24'h6a5500};

    // Clock at 250 MHz
    always #2 clk = ~clk;

    tcp_pwm_timer DUT (
        .REF_CLK_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr), .REG_WR_IN(wr), .REG_RD_IN(rd),
        .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .CHANNEL_ENABLE_BIT_IN(en), .START_POLARITY_IN(pol),
        .CENTER_ALIGN_SELECT_IN(ctr), .CHANNEL_CLOCK_CHOICE_IN(cho), .PWM_OUT(pwm)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and comparisons
    task automatic complete_run();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_count(input int got, input int exp);
        num_checks++;
        if (got != exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Register port cycles, one strobe cycle each
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Output measurement, sampled on the falling edge
    task automatic wait_level(input logic ch, input logic lvl, inout int n);
        int lim;
        lim = n + 3000;
        while (pwm[ch] !== lvl) begin
            @(negedge clk);
            n++;
            if (n > lim) begin
                n_mismatch++;
                $display("CHECK FAILED at %0t: output %0d stuck", $time, ch);
                complete_run();
            end
        end
    endtask

    // Cycles from one rising edge to the next
    task automatic period_of(input logic ch, output int p);
        int n;
        n = 0;
        wait_level(ch, 1'b0, n);
        wait_level(ch, 1'b1, n);
        n = 0;
        wait_level(ch, 1'b0, n);
        wait_level(ch, 1'b1, n);
        p = n;
    endtask

    task automatic count_high(input logic ch, input int n, output int h);
        h = 0;
        repeat (n) begin
            @(negedge clk);
            if (pwm[ch] === 1'b1) begin
                h++;
            end
        end
    endtask

    // Program a disabled channel, restart its counter, enable, count high cycles
    task automatic run_wave(input logic ch, input logic p, input logic c, input logic [7:0] per,
                            input logic [7:0] dty, input int exp);
        int h;
        @(posedge clk);
        en[ch] <= 1'b0;
        pol[ch] <= p;
        ctr[ch] <= c;
        reg_wr(8'h66 + {7'h00, ch}, per);
        reg_wr(8'h68 + {7'h00, ch}, dty);
        reg_wr(8'h64 + {7'h00, ch}, 8'h00);
        @(posedge clk);
        en[ch] <= 1'b1;
        repeat (20) @(posedge clk);
        count_high(ch, 40, h);
        chk_count(h, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [7:0] d;
        int p;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 8'h61; a <= 8'h69; a++) begin
            reg_rd(a[7:0], d);
            chk_byte(d, 8'h00);
        end
        for (int i = 0; i < 9; i++) begin
            reg_wr(rows[i][23:16], rows[i][15:8]);
            reg_rd(rows[i][23:16], d);
            chk_byte(d, rows[i][7:0]);
        end
        reg_wr(8'h61, 8'h00);
        run_wave(1'b0, 1'b0, 1'b0, 8'h04, 8'h01, 30);
        run_wave(1'b0, 1'b1, 1'b0, 8'h04, 8'h01, 10);
        run_wave(1'b1, 1'b0, 1'b1, 8'h04, 8'h01, 30);
        // New period and duty while running, forced in by a counter write
        reg_wr(8'h66, 8'h08);
        reg_wr(8'h68, 8'h04);
        reg_rd(8'h66, d);
        chk_byte(d, 8'h08);
        reg_wr(8'h64, 8'h00);
        repeat (20) @(posedge clk);
        count_high(1'b0, 40, p);
        chk_count(p, 20);
        run_wave(1'b1, 1'b0, 1'b0, 8'h02, 8'h01, 20);
        for (int s = 0; s < 8; s++) begin
            reg_wr(8'h61, {1'b0, s[2:0], 4'h0});
            period_of(1'b1, p);
            period_of(1'b1, p);
            chk_count(p, 2 << s);
        end
        // Scaled clocks on both channels, set up while both are stopped
        reg_wr(8'h61, 8'h00);
        @(posedge clk);
        en <= 2'b00;
        cho <= 2'b11;
        reg_wr(8'h66, 8'h02);
        reg_wr(8'h68, 8'h01);
        reg_wr(8'h62, 8'h03);
        reg_wr(8'h63, 8'h01);
        @(posedge clk);
        en <= 2'b11;
        period_of(1'b0, p);
        period_of(1'b0, p);
        chk_count(p, 12);
        period_of(1'b1, p);
        chk_count(p, 4);
        @(posedge clk);
        en <= 2'b00;
        reg_wr(8'h62, 8'h00);
        @(posedge clk);
        en <= 2'b11;
        period_of(1'b0, p);
        period_of(1'b0, p);
        chk_count(p, 1024);
        // Disable both channels, then reset in mid-run
        @(posedge clk);
        en <= 2'b00;
        repeat (4) @(posedge clk);
        count_high(1'b0, 20, p);
        chk_count(p, 0);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        reg_rd(8'h66, d);
        chk_byte(d, 8'h00);
        complete_run();
    end

    // Watchdog on the whole run
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        complete_run();
    end
endmodule // test_tcp_pwm_timer
